//--- core_regulator_sequencer_map.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: A 40 MHz system clock and a 32-bit Wishbone register bus.
// Notes: Times are kept in ns; cycle counts are derived from them.
`ifndef CORE_REGULATOR_SEQUENCER_MAP_SVH
`define CORE_REGULATOR_SEQUENCER_MAP_SVH

// Clock period in ns.
`define CRS_CLK_NS 25
// Hold above the boot level before clocks are permitted, least time.
`define CRS_HOLD_NS 73000
`define CRS_HOLD_CYC ((`CRS_HOLD_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// Protection mask window after a deep-sleep request, least time.
`define CRS_DSMASK_NS 73000
`define CRS_DSMASK_CYC ((`CRS_DSMASK_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// Output-good delay after clock permit in CPU mode, least time.
`define CRS_PG_CPU_NS 4700000
`define CRS_PG_CPU_CYC ((`CRS_PG_CPU_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// Output-good delay after settling in render mode, least time.
`define CRS_PG_RND_NS 4770000
`define CRS_PG_RND_CYC ((`CRS_PG_RND_NS + `CRS_CLK_NS - 1) / `CRS_CLK_NS)
// Power-up ramp deadline, longest time.
`define CRS_RAMP_NS 1000000
`define CRS_RAMP_CYC (`CRS_RAMP_NS / `CRS_CLK_NS)
// Switching cycles of current limiting that trip over-current.
`define CRS_OC_SWCYC 15

// Register byte offsets.
`define CRS_CTRL_OFS 8'h00
`define CRS_STAT_OFS 8'h04
`define CRS_EVENT_OFS 8'h08
`define CRS_MASK_OFS 8'h0c

// Control register fields and reset value.
`define CRS_CTRL_OCEN_BIT 0
`define CRS_CTRL_UVEN_BIT 1
`define CRS_CTRL_RST 2'h3

// Event and mask register fields.
`define CRS_EV_OUTPUT_GOOD_BIT 0
`define CRS_EV_OCTRIP_BIT 1
`define CRS_EV_UVTRIP_BIT 2
`define CRS_EV_OVSEEN_BIT 3
`define CRS_EV_LATE_BIT 4
`define CRS_EV_OFF_BIT 5
`define CRS_EV_W 6
`define CRS_MASK_RST 6'h00

`endif

//--- core_regulator_sequencer_pkg.sv
// Purpose: Types shared by the regulator sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Sequencer states are Gray coded along the CPU power-up path.
package core_regulator_sequencer_pkg;

    // Sequencer states; neighbours along the CPU power-up path differ by one bit.
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_RAMP = 3'h1,
        SEQ_SETTLE = 3'h3,
        SEQ_CLKWAIT = 3'h2,
        SEQ_ACTIVE = 3'h6,
        SEQ_SHUTDOWN = 3'h7,
        SEQ_LATCHED = 3'h5
    } seq_state_t;

    // Soft-start current source selection.
    typedef enum logic [1:0] {
        SLEW_NONE = 2'h0,
        SLEW_LOW = 2'h1,
        SLEW_MID = 2'h2,
        SLEW_HIGH = 2'h3
    } slew_sel_t;

endpackage

//--- core_regulator_sequencer.sv
// Purpose: Power-up, power-down and fault sequencing of a core regulator.
// Assumes: Comparator results are synchronous digital inputs on clk_sys.
// Notes: Registers are reached over classic Wishbone, one word each.
`timescale 1ns/1ps
`default_nettype none
`include "core_regulator_sequencer_map.svh"

// Contract
// - Start power-up when supply good and regulator-on high.
// - Strap high selects CPU, low selects render.
// - CPU ramps to boot level, lowest slew current.
// - Permit clocks after 73 us above boot-0.1V.
// - Then ramp from boot level to DAC target.
// - Output-good about 4.7 ms after clock permit.
// - Ignore deep-sleep request until output-good.
// - Mask under-voltage while below ramp target.
// - Render: output-good after 4.77 ms near target.
// - Regulator-off drops output-good, slow ramp down.
// - Below 200 mV: gates off, discharge, analog off.
// - Slew current chosen by activity: low/mid/high.
// - Deep-sleep request masks UV, OC, OV for 73 us.
// - Current limit holds high-side gate off.
// - Fifteen limited switching cycles trip over-current.
// - Over-current trip latches until regulator-on cycles.
// - Deep-sleep selects light-load mode, else continuous.
module core_regulator_sequencer #(
    parameter int unsigned CNT_W = 18,
    parameter int unsigned PG_CPU_CYC = `CRS_PG_CPU_CYC,
    parameter int unsigned PG_RND_CYC = `CRS_PG_RND_CYC,
    parameter int unsigned RAMP_CYC = `CRS_RAMP_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic supplyOk,
    input wire logic regulator_on,
    input wire logic deep_sleep_request,
    input wire logic cpuClockPermitIn,
    output logic cpuClockPermitOut,
    output logic cpuClockPermitDriveN,
    input wire logic senseNearTarget,
    input wire logic senseBelowOff,
    input wire logic underVoltageCmp,
    input wire logic overVoltageCmp,
    input wire logic currentLimitCmp,
    input wire logic switchCycle,
    input wire logic dacSlewing,
    input wire logic dacRising,
    output logic output_good,
    output logic highSideEnable,
    output logic lowSideEnable,
    output logic dischargeEnable,
    output logic analogEnable,
    output logic targetIsDac,
    output logic [1:0] slewSelect,
    output logic underVoltageMask,
    output logic overVoltageMask,
    output logic overCurrentMask,
    output logic ring_free_light_load,
    output logic irq,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    // Refuse delays that the counters cannot hold or that are zero.
    if (CNT_W < 13 || CNT_W > 31) begin : g_bad_width
        $error("CNT_W must lie between 13 and 31");
    end
    if (PG_CPU_CYC < 1 || PG_CPU_CYC >= (1 << CNT_W) ||
        PG_RND_CYC < 1 || PG_RND_CYC >= (1 << CNT_W) ||
        RAMP_CYC < 1 || RAMP_CYC >= (1 << CNT_W)) begin : g_bad_count
        $error("Delay counts must be nonzero and fit in CNT_W bits");
    end

    localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(`CRS_HOLD_CYC);
    localparam logic [CNT_W-1:0] DSMASK_LIM = CNT_W'(`CRS_DSMASK_CYC);
    localparam logic [3:0] OC_LIM = 4'(`CRS_OC_SWCYC);

    // Terminal count of a delay: the last cycle of a span of n cycles.
    function automatic logic [CNT_W-1:0] lastCycle(input int unsigned n);
        lastCycle = CNT_W'(n - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state.
    ////////////////////////////////////////////////////////////////////////

    core_regulator_sequencer_pkg::seq_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] rampCnt_reg, rampCnt_next;
    logic [CNT_W-1:0] maskCnt_reg, maskCnt_next;
    logic [3:0] ocCnt_reg, ocCnt_next;
    logic cpuMode_reg, cpuMode_next;
    logic dsPrev_reg, dsPrev_next;
    logic llPrev_reg, llPrev_next;
    logic clkDrive_reg, clkDrive_next;
    logic targetDac_reg, targetDac_next;
    logic good_reg, good_next;
    logic hs_reg, hs_next;
    logic ls_reg, ls_next;
    logic dis_reg, dis_next;
    logic ana_reg, ana_next;
    core_regulator_sequencer_pkg::slew_sel_t slew_reg, slew_next;
    logic uvm_reg, uvm_next;
    logic ovm_reg, ovm_next;
    logic ocm_reg, ocm_next;
    logic ll_reg, ll_next;
    logic evGood, evOcTrip, evUvTrip, evOvSeen, evLate, evOff;
    logic [1:0] ctrl_reg, ctrl_next;

    // Next state of the sequencer, its timers and its pin levels.
    always_comb begin
        logic powered;
        logic protMask;
        logic ocTrip;
        logic uvTrip;
        powered = 1'b0;
        protMask = (maskCnt_reg != '0);
        ocTrip = 1'b0;
        uvTrip = 1'b0;
        state_next = state_reg;
        cnt_next = cnt_reg;
        rampCnt_next = rampCnt_reg;
        maskCnt_next = protMask ? maskCnt_reg - 1'b1 : maskCnt_reg;
        ocCnt_next = ocCnt_reg;
        cpuMode_next = cpuMode_reg;
        dsPrev_next = deep_sleep_request;
        llPrev_next = ll_reg;
        clkDrive_next = clkDrive_reg;
        targetDac_next = targetDac_reg;
        good_next = good_reg;
        slew_next = slew_reg;
        ll_next = ll_reg;
        evGood = 1'b0;
        evOcTrip = 1'b0;
        evUvTrip = 1'b0;
        evOvSeen = 1'b0;
        evLate = 1'b0;
        evOff = 1'b0;
        case (state_reg)
            core_regulator_sequencer_pkg::SEQ_IDLE: begin
                cnt_next = '0;
                rampCnt_next = '0;
                ocCnt_next = '0;
                clkDrive_next = 1'b0;
                good_next = 1'b0;
                ll_next = 1'b0;
                slew_next = core_regulator_sequencer_pkg::SLEW_NONE;
                if (supplyOk && regulator_on) begin
                    cpuMode_next = cpuClockPermitIn;
                    targetDac_next = ~cpuClockPermitIn;
                    slew_next = core_regulator_sequencer_pkg::SLEW_LOW;
                    state_next = core_regulator_sequencer_pkg::SEQ_RAMP;
                end
            end
            core_regulator_sequencer_pkg::SEQ_RAMP: begin
                // Soft-start toward boot (CPU) or DAC (render).
                powered = 1'b1;
                slew_next = core_regulator_sequencer_pkg::SLEW_LOW;
                if (rampCnt_reg == lastCycle(RAMP_CYC)) begin
                    evLate = 1'b1;
                end
                if (rampCnt_reg != lastCycle(RAMP_CYC)) begin
                    rampCnt_next = rampCnt_reg + 1'b1;
                end
                if (senseNearTarget) begin
                    cnt_next = '0;
                    state_next = core_regulator_sequencer_pkg::SEQ_SETTLE;
                end
            end
            core_regulator_sequencer_pkg::SEQ_SETTLE: begin
                // Sensed output must stay near target for the whole span.
                powered = 1'b1;
                slew_next = core_regulator_sequencer_pkg::SLEW_LOW;
                cnt_next = senseNearTarget ? cnt_reg + 1'b1 : '0;
                if (cpuMode_reg && senseNearTarget &&
                    cnt_reg == HOLD_LIM - 1'b1) begin
                    clkDrive_next = 1'b1;
                    targetDac_next = 1'b1;
                    slew_next = core_regulator_sequencer_pkg::SLEW_MID;
                    cnt_next = '0;
                    state_next = core_regulator_sequencer_pkg::SEQ_CLKWAIT;
                end else if (!cpuMode_reg && senseNearTarget &&
                    cnt_reg == lastCycle(PG_RND_CYC)) begin
                    good_next = 1'b1;
                    evGood = 1'b1;
                    state_next = core_regulator_sequencer_pkg::SEQ_ACTIVE;
                end
            end
            core_regulator_sequencer_pkg::SEQ_CLKWAIT: begin
                powered = 1'b1;
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == lastCycle(PG_CPU_CYC)) begin
                    good_next = 1'b1;
                    evGood = 1'b1;
                    state_next = core_regulator_sequencer_pkg::SEQ_ACTIVE;
                end
            end
            core_regulator_sequencer_pkg::SEQ_ACTIVE: begin
                powered = 1'b1;
                ll_next = deep_sleep_request;
                if (deep_sleep_request && !dsPrev_reg) begin
                    maskCnt_next = DSMASK_LIM;
                end
                // Slew: mid for target and mode moves, high for render
                // light-load upward moves.
                if (dacSlewing && dacRising && ll_reg && !cpuMode_reg) begin
                    slew_next = core_regulator_sequencer_pkg::SLEW_HIGH;
                end else begin
                    slew_next = core_regulator_sequencer_pkg::SLEW_MID;
                end
                uvTrip = ctrl_reg[`CRS_CTRL_UVEN_BIT] && underVoltageCmp &&
                    !protMask;
                if (overVoltageCmp && !protMask) begin
                    evOvSeen = 1'b1;
                end
            end
            core_regulator_sequencer_pkg::SEQ_SHUTDOWN: begin
                slew_next = core_regulator_sequencer_pkg::SLEW_LOW;
                good_next = 1'b0;
                if (senseBelowOff) begin
                    evOff = 1'b1;
                    state_next = core_regulator_sequencer_pkg::SEQ_IDLE;
                end
            end
            core_regulator_sequencer_pkg::SEQ_LATCHED: begin
                good_next = 1'b0;
                clkDrive_next = 1'b0;
                slew_next = core_regulator_sequencer_pkg::SLEW_NONE;
            end
            default: begin
                state_next = core_regulator_sequencer_pkg::SEQ_IDLE;
            end
        endcase
        // Over-current counts limited switching cycles while powered.
        if (powered && switchCycle && !protMask) begin
            if (currentLimitCmp) begin
                ocCnt_next = ocCnt_reg + 1'b1;
            end else begin
                ocCnt_next = '0;
            end
            ocTrip = currentLimitCmp && ocCnt_reg == OC_LIM - 1'b1 &&
                ctrl_reg[`CRS_CTRL_OCEN_BIT];
        end
        if (ocTrip || uvTrip) begin
            evOcTrip = ocTrip;
            evUvTrip = uvTrip;
            good_next = 1'b0;
            state_next = core_regulator_sequencer_pkg::SEQ_LATCHED;
        end
        // Regulator-off or supply loss overrides everything else.
        if (!supplyOk) begin
            good_next = 1'b0;
            state_next = core_regulator_sequencer_pkg::SEQ_IDLE;
        end else if (!regulator_on &&
            state_reg != core_regulator_sequencer_pkg::SEQ_IDLE) begin
            good_next = 1'b0;
            clkDrive_next = 1'b0;
            ll_next = 1'b0;
            if (state_reg == core_regulator_sequencer_pkg::SEQ_LATCHED) begin
                state_next = core_regulator_sequencer_pkg::SEQ_IDLE;
            end else if (state_reg !=
                core_regulator_sequencer_pkg::SEQ_SHUTDOWN) begin
                slew_next = core_regulator_sequencer_pkg::SLEW_LOW;
                state_next = core_regulator_sequencer_pkg::SEQ_SHUTDOWN;
            end
        end
        // Mode change between light-load and continuous uses mid slew.
        if (state_reg == core_regulator_sequencer_pkg::SEQ_ACTIVE &&
            ll_reg != llPrev_reg && regulator_on) begin
            slew_next = core_regulator_sequencer_pkg::SLEW_MID;
        end
        // Pin levels follow the next state.
        case (state_next)
            core_regulator_sequencer_pkg::SEQ_RAMP,
            core_regulator_sequencer_pkg::SEQ_SETTLE,
            core_regulator_sequencer_pkg::SEQ_CLKWAIT,
            core_regulator_sequencer_pkg::SEQ_ACTIVE,
            core_regulator_sequencer_pkg::SEQ_SHUTDOWN: begin
                hs_next = !currentLimitCmp;
                ls_next = 1'b1;
                dis_next = 1'b0;
                ana_next = 1'b1;
            end
            default: begin
                hs_next = 1'b0;
                ls_next = 1'b0;
                dis_next = 1'b1;
                ana_next = (state_next ==
                    core_regulator_sequencer_pkg::SEQ_LATCHED);
            end
        endcase
        // Under-voltage masked below target during power-up.
        uvm_next = maskCnt_next != '0;
        if (state_next == core_regulator_sequencer_pkg::SEQ_RAMP ||
            state_next == core_regulator_sequencer_pkg::SEQ_SETTLE ||
            (state_next == core_regulator_sequencer_pkg::SEQ_CLKWAIT &&
             !senseNearTarget)) begin
            uvm_next = uvm_next || !senseNearTarget;
        end
        ovm_next = maskCnt_next != '0;
        ocm_next = maskCnt_next != '0;
    end

    // Sequencer registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= core_regulator_sequencer_pkg::SEQ_IDLE;
            cnt_reg <= '0;
            rampCnt_reg <= '0;
            maskCnt_reg <= '0;
            ocCnt_reg <= 4'h0;
            cpuMode_reg <= 1'b0;
            dsPrev_reg <= 1'b0;
            llPrev_reg <= 1'b0;
            clkDrive_reg <= 1'b0;
            targetDac_reg <= 1'b0;
            good_reg <= 1'b0;
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
            dis_reg <= 1'b1;
            ana_reg <= 1'b0;
            slew_reg <= core_regulator_sequencer_pkg::SLEW_NONE;
            uvm_reg <= 1'b1;
            ovm_reg <= 1'b0;
            ocm_reg <= 1'b0;
            ll_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rampCnt_reg <= rampCnt_next;
            maskCnt_reg <= maskCnt_next;
            ocCnt_reg <= ocCnt_next;
            cpuMode_reg <= cpuMode_next;
            dsPrev_reg <= dsPrev_next;
            llPrev_reg <= llPrev_next;
            clkDrive_reg <= clkDrive_next;
            targetDac_reg <= targetDac_next;
            good_reg <= good_next;
            hs_reg <= hs_next;
            ls_reg <= ls_next;
            dis_reg <= dis_next;
            ana_reg <= ana_next;
            slew_reg <= slew_next;
            uvm_reg <= uvm_next;
            ovm_reg <= ovm_next;
            ocm_reg <= ocm_next;
            ll_reg <= ll_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone registers and interrupt.
    ////////////////////////////////////////////////////////////////////////

    logic [`CRS_EV_W-1:0] event_reg, event_next;
    logic [`CRS_EV_W-1:0] mask_reg, mask_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    logic irq_reg, irq_next;

    // Decode, sticky events with read-to-clear, and the interrupt level.
    always_comb begin
        logic access;
        logic [`CRS_EV_W-1:0] setBits;
        access = cyc_i && stb_i && !ack_reg;
        setBits = {evOff, evLate, evOvSeen, evUvTrip, evOcTrip, evGood};
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        event_next = event_reg;
        dat_next = dat_reg;
        ack_next = access;
        if (access && we_i && sel_i[0]) begin
            case (adr_i)
                `CRS_CTRL_OFS: ctrl_next = dat_i[1:0];
                `CRS_MASK_OFS: mask_next = dat_i[`CRS_EV_W-1:0];
                default: begin
                end
            endcase
        end
        if (access && !we_i) begin
            case (adr_i)
                `CRS_CTRL_OFS: dat_next = {30'h0, ctrl_reg};
                `CRS_STAT_OFS: dat_next = {23'h0, ll_reg, clkDrive_reg,
                    cpuMode_reg, good_reg, 2'h0, state_reg};
                `CRS_EVENT_OFS: begin
                    dat_next = {26'h0, event_reg};
                    event_next = '0;
                end
                `CRS_MASK_OFS: dat_next = {26'h0, mask_reg};
                default: dat_next = 32'h0;
            endcase
        end
        // A new event in the clearing cycle survives.
        event_next = event_next | setBits;
        irq_next = |(event_next & mask_next);
    end

    // Bus and interrupt registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CRS_CTRL_RST;
            mask_reg <= `CRS_MASK_RST;
            event_reg <= '0;
            dat_reg <= 32'h0;
            ack_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            event_reg <= event_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
            irq_reg <= irq_next;
        end
    end

    // Outputs straight from flip-flops except cpuClockPermitOut, tied low, and cpuClockPermitDriveN, inverted; the permit pin is driven only low.
    assign cpuClockPermitOut = 1'b0;
    assign cpuClockPermitDriveN = ~clkDrive_reg;
    assign output_good = good_reg;
    assign highSideEnable = hs_reg;
    assign lowSideEnable = ls_reg;
    assign dischargeEnable = dis_reg;
    assign analogEnable = ana_reg;
    assign targetIsDac = targetDac_reg;
    assign slewSelect = slew_reg;
    assign underVoltageMask = uvm_reg;
    assign overVoltageMask = ovm_reg;
    assign overCurrentMask = ocm_reg;
    assign ring_free_light_load = ll_reg;
    assign irq = irq_reg;
    assign dat_o = dat_reg;
    assign ack_o = ack_reg;

endmodule // core_regulator_sequencer

`default_nettype wire

//--- core_regulator_sequencer_chk.sv
// Purpose: Concurrent checks on the sequencer ports.
// Assumes: One clock domain, rst_n async low.
// Notes: Bound into every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module core_regulator_sequencer_chk #(
    parameter int unsigned PG_CPU_CYC = 50
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic supplyOk,
    input wire logic regulator_on,
    input wire logic deep_sleep_request,
    input wire logic currentLimitCmp,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic output_good,
    input wire logic cpuClockPermitDriveN,
    input wire logic targetIsDac,
    input wire logic [1:0] slewSelect,
    input wire logic highSideEnable,
    input wire logic lowSideEnable,
    input wire logic dischargeEnable,
    input wire logic analogEnable,
    input wire logic ring_free_light_load,
    input wire logic overCurrentMask
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [17:0] pgCnt_reg, pgCnt_next;
    // Counts cycles since clocks were permitted.
    always_comb begin
        pgCnt_next = cpuClockPermitDriveN ? 18'h00000 : pgCnt_reg + 18'h00001;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pgCnt_reg <= 18'h00000;
        end else begin
            pgCnt_reg <= pgCnt_next;
        end
    end
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    AST_PG_DROP: assert property (!regulator_on |=> !output_good)
        else $error("output good stayed");
    AST_OFF_SLEW: assert property (!regulator_on && output_good |=>
        slewSelect == 2'h1) else $error("slew not low");
    AST_DS_IGNORE: assert property ($rose(ring_free_light_load) |->
        output_good) else $error("sleep honoured early");
    AST_HS_LIMIT: assert property (currentLimitCmp |=> !highSideEnable)
        else $error("high side on in limit");
    AST_PERMIT_DAC: assert property ($fell(cpuClockPermitDriveN) |->
        targetIsDac) else $error("target not dac");
    AST_GATES_OFF: assert property ($rose(dischargeEnable) |->
        !highSideEnable && !lowSideEnable) else $error("gates on");
    AST_LATCH_HOLD: assert property (dischargeEnable && analogEnable &&
        regulator_on && supplyOk |=> dischargeEnable) else $error("unlatched");
    AST_DS_MASK: assert property ($rose(deep_sleep_request) &&
        output_good |-> ##[1:3] overCurrentMask[*8]) else $error("mask short");
    AST_PG_DELAY: assert property ($rose(output_good) &&
        !cpuClockPermitDriveN |-> pgCnt_reg + 2 >= PG_CPU_CYC &&
        pgCnt_reg <= PG_CPU_CYC + 2) else $error("output good delay");
    COV_PG: cover property ($rose(output_good));
    COV_LATCH: cover property ($rose(dischargeEnable) && analogEnable);
    COV_SLEEP: cover property ($rose(ring_free_light_load));
endmodule // core_regulator_sequencer_chk
bind core_regulator_sequencer core_regulator_sequencer_chk #(
    .PG_CPU_CYC(PG_CPU_CYC)) chk_i (.*);
`default_nettype wire

//--- core_clock_permit_model.sv
// Purpose: Board strap and pin of the clock permit line.
// Assumes: Pull-up fitted for CPU, ground tie for render.
// Notes: The pin reads the strap unless the sequencer drives it.
`timescale 1ns/1ps
`default_nettype none
module core_clock_permit_model (
    input wire logic strapHigh,
    input wire logic driveN,
    input wire logic driveVal,
    output logic pinLevel
);
    // Resolves the pin from the strap and the drive enable.
    assign pinLevel = driveN ? strapHigh : driveVal;
endmodule // core_clock_permit_model
`default_nettype wire

//--- test_core_regulator_sequencer.sv
// Purpose: Self-checking bench of the regulator sequencer.
// Assumes: Small power-good counts set by parameter.
// Notes: Bus cycles through one shared task.
`timescale 1ns/1ps
`default_nettype none
module test_core_regulator_sequencer;
    logic clk_sys = 1'b0, rst_n = 1'b0, supplyOk = 1'b0, regOn = 1'b0;
    logic dsReq = 1'b0, strapHigh = 1'b1, near = 1'b0, belowOff = 1'b0;
    logic limit = 1'b0, swPulse = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, datO;
    logic pin, drvVal, drvN, pg, hs, ls, dis, ana, tgt, uvm, ovm, ocm;
    logic rfl, irq, ack, uvC = 1'b0, ovC = 1'b0, dac = 1'b0;
    logic [1:0] slew;
    int fails = 0, checked = 0, n;
    always #12.5 clk_sys = ~clk_sys;
    core_clock_permit_model core_clock_permit_model_i (.strapHigh(strapHigh),
        .driveN(drvN), .driveVal(drvVal), .pinLevel(pin));
    core_regulator_sequencer #(.PG_CPU_CYC(50), .PG_RND_CYC(60),
        .RAMP_CYC(20)) core_regulator_sequencer_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .supplyOk(supplyOk), .regulator_on(regOn),
        .deep_sleep_request(dsReq), .cpuClockPermitIn(pin),
        .cpuClockPermitOut(drvVal), .cpuClockPermitDriveN(drvN),
        .senseNearTarget(near), .senseBelowOff(belowOff),
        .underVoltageCmp(uvC), .overVoltageCmp(ovC),
        .currentLimitCmp(limit), .switchCycle(swPulse), .dacSlewing(dac),
        .dacRising(dac), .output_good(pg), .highSideEnable(hs),
        .lowSideEnable(ls), .dischargeEnable(dis), .analogEnable(ana),
        .targetIsDac(tgt), .slewSelect(slew), .underVoltageMask(uvm),
        .overVoltageMask(ovm), .overCurrentMask(ocm),
        .ring_free_light_load(rfl), .irq(irq), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(datO),
        .ack_o(ack));
    // Compares a seen value with the expected one.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        rdat = datO;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Waits a number of clock edges.
    task tick(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    // One switching cycle pulse.
    task sw;
        swPulse <= 1'b1; tick(1); swPulse <= 1'b0; tick(1);
    endtask
    // Prints the counts and the verdict, then stops.
    task conclude;
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #(25 * 20000);
        fails++;
        conclude();
    end
    // Register checks, CPU and render power-up, sleep, shutdown, trip.
    initial begin
        tick(5); rst_n <= 1'b1; tick(1);
        wb(0, 8'h00, 0); chk(rdat, 32'h3);
        wb(0, 8'h0c, 0); chk(rdat, 32'h0);
        wb(0, 8'h40, 0); chk(rdat, 32'h0);
        wb(1, 8'h0c, 32'h3);
        supplyOk <= 1'b1; regOn <= 1'b1; tick(2);
        chk(slew, 2'h1);
        near <= 1'b1;
        for (n = 0; n < 4000 && drvN !== 1'b0; n++) tick(1);
        chk(32'(n >= 2919 && n <= 2925), 1);
        chk(tgt, 1);
        for (n = 0; n < 200 && pg !== 1'b1; n++) tick(1);
        chk(32'(n >= 48 && n <= 53), 1);
        chk(irq, 1);
        wb(0, 8'h08, 0); chk(rdat, 32'h1);
        tick(1); chk(irq, 0);
        dsReq <= 1'b1; tick(3);
        chk(rfl, 1);
        chk(ocm, 1);
        dsReq <= 1'b0; regOn <= 1'b0; tick(2);
        chk(pg, 0);
        chk(slew, 2'h1);
        belowOff <= 1'b1; tick(3);
        chk({hs, ls, dis, ana}, 4'h2);
        strapHigh <= 1'b0; belowOff <= 1'b0; near <= 1'b0; regOn <= 1'b1;
        dsReq <= 1'b1; tick(3); chk(rfl, 0); near <= 1'b1;
        for (n = 0; n < 300 && pg !== 1'b1; n++) tick(1);
        chk(32'(n >= 58 && n <= 64), 1);
        dsReq <= 1'b0; chk(drvN, 1);
        while (ocm !== 1'b0) tick(1);
        limit <= 1'b1; tick(2);
        chk(hs, 0);
        repeat (14) sw();
        chk(dis, 0);
        sw(); tick(1); limit <= 1'b0; tick(2);
        chk({hs, ls, dis, pg}, 4'h2);
        wb(0, 8'h08, 0); chk(rdat, 32'h23);
        tick(5); chk(dis, 1);
        regOn <= 1'b0; tick(3); regOn <= 1'b1; tick(4);
        chk(dis, 0);
        conclude();
    end
endmodule // test_core_regulator_sequencer
`default_nettype wire
